// ### eeprom_rd.sv
// serial eeprom slave: reads, protect register reads and write-busy polling
`timescale 1ns/100ps
`include "eeprom_rd_cfg.svh"

module eeprom_rd
   import eeprom_rd_pkg::*;
#(
   parameter int         ADDR_W       = `ADDR_BITS,
   parameter int         WRITE_CYCLES = `WRITE_CYCLES,
   parameter logic [3:0] DEV_TYPE     = 4'h6          // arbitrary value
) (
   input  wire logic       sys_clk,       // system clock, 40 MHz
   input  wire logic       reset_n,       // active low reset; synchronous on sys_clk, clears detectors and drive asynchronously
   input  wire logic       scl,           // serial clock from the master
   input  wire logic       sda_in,        // serial data line level
   output wire logic       sda_out,       // serial data drive value
   output wire logic       sda_oe,        // high while pulling data low
   input  wire logic [2:0] chip_enable,   // chip enable address strap
   output wire logic       write_busy,    // internal write cycle running
   output wire logic [3:0] protect_bits   // stored protect settings
);
   localparam int DEPTH = 1 << ADDR_W;

   logic [7:0]        mem_q [DEPTH];
   logic [3:0]        prot_q;
   logic              busy_q;
   logic [31:0]       timer_q;
   logic              la_q, lb_q, lc_q;
   logic              start_tog_q, stop_tog_q, launch_tog_q;
   logic              start_seen_q, stop_seen_q;
   logic              lrst_a_q, lrst_n_q;
   logic              busy_a_q, busy_l_q;
   logic [2:0]        ce_a_q, ce_q;
   link_state_type    state_q;
   logic [3:0]        bit_q;
   logic [7:0]        shift_q, hi_q, out_q;
   logic              ack_q, rw_q, armed_q, prot_sel_q, oe_q;
   logic [ADDR_W-1:0] addr_q;
   wr_req_type        wr_q;
   logic              new_start, new_stop, active, byte_done, slot_end;
   logic              sel_match, load_rd, launch_ev, commit;
   logic [7:0]        byte_in, rd_byte;

   // ---------------- system clock side: write cycle and storage ----------------

   // launch toggle crosses in by two flip-flops, third one finds the edge
   always_ff @(posedge sys_clk) begin
      la_q <= launch_tog_q;
      lb_q <= la_q;
      lc_q <= lb_q;
   end
   assign launch_ev = lb_q ^ lc_q;
   assign commit    = busy_q && (timer_q == 32'h0);

   // busy timer; a second launch while busy cannot occur, selects are refused
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         busy_q  <= 1'b0;
         timer_q <= 32'h0;
      end else if (launch_ev && !busy_q) begin
         busy_q  <= 1'b1;
         timer_q <= 32'(WRITE_CYCLES - 1);
      end else if (busy_q) begin
         if (timer_q == 32'h0) busy_q <= 1'b0;
         else timer_q <= timer_q - 32'h1;
      end
   end

   // latched byte lands in the cells at the end of the cycle
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         for (int i = 0; i < DEPTH; i++) mem_q[i] <= `ERASED_BYTE;
      end else if (commit && !wr_q.prot_sel) begin
         mem_q[wr_q.addr[ADDR_W-1:0]] <= wr_q.data;
      end
   end

   // protect register, frozen once the lock bit is set
   always_ff @(posedge sys_clk) begin
      if (!reset_n) prot_q <= `PROTECT_RESET;
      else if (commit && wr_q.prot_sel && !prot_q[`PROTECT_LOCK]) prot_q <= wr_q.data[3:0];
   end

   assign write_busy   = busy_q;
   assign protect_bits = prot_q;

   // ---------------- bus condition detectors on data edges ----------------
   // these have no dependable clock during reset, hence the asynchronous clear

   // start: data falls while the clock is high
   always_ff @(negedge sda_in or negedge reset_n) begin
      if (!reset_n) start_tog_q <= 1'b0;
      else if (scl) start_tog_q <= ~start_tog_q;
   end

   // stop: data rises while the clock is high; after write data it launches the cycle
   always_ff @(posedge sda_in or negedge reset_n) begin
      if (!reset_n) begin
         stop_tog_q   <= 1'b0;
         launch_tog_q <= 1'b0;
      end else if (scl) begin
         stop_tog_q <= ~stop_tog_q;
         if (armed_q) launch_tog_q <= ~launch_tog_q;
      end
   end

   // ---------------- link side, clocked by the serial clock ----------------

   // reset, busy and strap levels cross in through two flip-flops
   always_ff @(posedge scl) begin
      lrst_a_q <= reset_n;
      lrst_n_q <= lrst_a_q;
      busy_a_q <= busy_q;
      busy_l_q <= busy_a_q;
      ce_a_q   <= chip_enable;
      ce_q     <= ce_a_q;
   end

   // condition toggles are stable for a whole clock high time, so read directly
   assign new_start = start_tog_q != start_seen_q;
   assign new_stop  = stop_tog_q != stop_seen_q;
   assign active    = (state_q != st_idle) && !new_start && !new_stop;
   assign byte_done = active && (bit_q == `BIT_LAST);
   assign slot_end  = active && (bit_q == `BIT_ACK);
   assign byte_in   = {shift_q[6:0], sda_in};
   assign sel_match = byte_in[7:1] == {DEV_TYPE, ce_q};
   assign load_rd   = slot_end && ((state_q == st_select && ack_q && rw_q) ||
                                   (state_q == st_rdata && !sda_in));
   // array and protect bits only change while busy, when no read can run
   assign rd_byte   = prot_sel_q ? {4'h0, prot_q} : mem_q[addr_q];

   // bit counter and shift register
   always_ff @(posedge scl) begin
      if (!lrst_n_q) begin
         start_seen_q <= 1'b0;
         stop_seen_q  <= 1'b0;
         bit_q        <= 4'h0;
         shift_q      <= 8'h00;
      end else begin
         start_seen_q <= start_tog_q;
         stop_seen_q  <= stop_tog_q;
         shift_q      <= byte_in;
         if (new_start) bit_q <= 4'h1;
         else if (new_stop || slot_end) bit_q <= 4'h0;
         else if (active) bit_q <= bit_q + 4'h1;
      end
   end

   // acknowledge decision at the eighth bit, held through the ninth slot
   always_ff @(posedge scl) begin
      if (!lrst_n_q) begin
         ack_q <= 1'b0;
         rw_q  <= 1'b0;
      end else if (byte_done) begin
         unique case (state_q)
            st_select: begin
               ack_q <= sel_match && !busy_l_q;
               rw_q  <= byte_in[0];
            end
            st_addr_hi, st_addr_lo, st_wdata: ack_q <= 1'b1;
            st_rdata: ack_q <= 1'b0;
            st_idle: ack_q <= 1'b0;
         endcase
      end else if (new_start || new_stop || slot_end) begin
         ack_q <= 1'b0;
      end
   end

   // instruction sequencing
   always_ff @(posedge scl) begin
      if (!lrst_n_q) begin
         state_q <= st_idle;
      end else if (new_start) begin
         state_q <= st_select;
      end else if (new_stop) begin
         state_q <= st_idle;
      end else if (slot_end) begin
         unique case (state_q)
            st_select:  state_q <= !ack_q ? st_idle : (rw_q ? st_rdata : st_addr_hi);
            st_addr_hi: state_q <= st_addr_lo;
            st_addr_lo: state_q <= st_wdata;
            st_wdata:   state_q <= st_wdata;
            st_rdata:   state_q <= sda_in ? st_idle : st_rdata;
            st_idle:    state_q <= st_idle;
         endcase
      end
   end

   // address counter and protect register selection
   always_ff @(posedge scl) begin
      if (!lrst_n_q) begin
         hi_q       <= 8'h00;
         addr_q     <= '0;
         prot_sel_q <= 1'b0;
      end else if (byte_done && state_q == st_addr_hi) begin
         hi_q <= byte_in;
      end else if (byte_done && state_q == st_addr_lo) begin
         addr_q     <= ADDR_W'({hi_q, byte_in});
         prot_sel_q <= hi_q[`PROTECT_SEL_BIT];
      end else if (load_rd && !prot_sel_q) begin
         addr_q <= addr_q + 1'b1;
      end
   end

   // write data latch; page sequencing is outside this block, last byte wins
   always_ff @(posedge scl) begin
      if (!lrst_n_q) begin
         armed_q <= 1'b0;
         wr_q    <= '0;
      end else if (new_start) begin
         armed_q <= 1'b0;
      end else if (byte_done && state_q == st_wdata) begin
         armed_q <= 1'b1;
         wr_q    <= '{prot_sel: prot_sel_q, addr: 16'(addr_q), data: byte_in};
      end
   end

   // read byte shifter, loaded at the ack slot so the falling edge can drive bit 7
   always_ff @(posedge scl) begin
      if (!lrst_n_q) out_q <= 8'h00;
      else if (load_rd) out_q <= rd_byte;
      else if (state_q == st_rdata && bit_q != `BIT_ACK) out_q <= {out_q[6:0], 1'b0};
   end

   // data line driven only on the falling clock, so it never moves while high
   always_ff @(negedge scl or negedge reset_n) begin
      if (!reset_n) oe_q <= 1'b0;
      else oe_q <= !busy_l_q && ((bit_q == `BIT_ACK && ack_q) ||
                                 (state_q == st_rdata && bit_q != `BIT_ACK && !out_q[7]));
   end

   assign sda_out = 1'b0;
   assign sda_oe  = oe_q;

   // ---------------- checks ----------------

   busy_refuse_a: assert property (@(posedge scl) disable iff (!lrst_n_q)
      (byte_done && state_q == st_select && busy_l_q) |=> !ack_q)
      else $error("select acknowledged during write cycle");
   poll_accept_a: assert property (@(posedge scl) disable iff (!lrst_n_q)
      (byte_done && state_q == st_select && sel_match && !busy_l_q) |=> ack_q)
      else $error("matching select not acknowledged when idle");
   noack_stop_a: assert property (@(posedge scl) disable iff (!lrst_n_q)
      (slot_end && state_q == st_rdata && sda_in) |=> state_q == st_idle)
      else $error("read continued after master no-ack");
   seq_advance_a: assert property (@(posedge scl) disable iff (!lrst_n_q)
      (load_rd && !prot_sel_q) |=> addr_q == $past(addr_q) + 1'b1)
      else $error("address counter did not advance");
   addr_wrap_a: assert property (@(posedge scl) disable iff (!lrst_n_q)
      (load_rd && !prot_sel_q && &addr_q) |=> addr_q == '0)
      else $error("address counter did not wrap to zero");
   prot_hold_a: assert property (@(posedge scl) disable iff (!lrst_n_q)
      (load_rd && prot_sel_q) |=> $stable(addr_q) && out_q[7:4] == 4'h0)
      else $error("protect read advanced or upper nibble nonzero");
   addr_order_a: assert property (@(posedge scl) disable iff (!lrst_n_q)
      (slot_end && state_q == st_addr_hi) |=> state_q == st_addr_lo ##9 (state_q != st_addr_lo))
      else $error("address bytes out of order");
   read_dir_a: assert property (@(posedge scl) disable iff (!lrst_n_q)
      (slot_end && state_q == st_select && ack_q && rw_q) |=> state_q == st_rdata && out_q == $past(rd_byte))
      else $error("read select did not start byte output");
   launch_busy_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (launch_ev && !busy_q) |=> busy_q && timer_q == 32'(WRITE_CYCLES - 1))
      else $error("write cycle not launched");

   // select decoding, address acks, quiet line while busy, lock and reset values
   wrong_sel_a: assert property (@(posedge scl) disable iff (!lrst_n_q)
      (byte_done && state_q == st_select && !sel_match) |=> !ack_q)
      else $error("foreign select acknowledged");
   addr_ack_a: assert property (@(posedge scl) disable iff (!lrst_n_q)
      (byte_done && (state_q == st_addr_hi || state_q == st_addr_lo)) |=> ack_q)
      else $error("address byte not acknowledged");
   busy_quiet_a: assert property (@(posedge scl) disable iff (!lrst_n_q)
      busy_l_q |-> !sda_oe)
      else $error("data line driven during write cycle");
   rd_noself_a: assert property (@(posedge scl) disable iff (!lrst_n_q)
      (byte_done && state_q == st_rdata) |=> !ack_q)
      else $error("device acknowledged its own read byte");
   lock_hold_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (commit && wr_q.prot_sel && prot_q[`PROTECT_LOCK]) |=> $stable(prot_q))
      else $error("locked protect bits changed");
   reset_state_a: assert property (@(posedge sys_clk)
      !reset_n |=> !busy_q && prot_q == `PROTECT_RESET)
      else $error("reset values not restored");
endmodule

// ### eeprom_rd_cfg.svh
// constants for the serial eeprom read and acknowledge-polling block
`ifndef EEPROM_RD_CFG_SVH
`define EEPROM_RD_CFG_SVH
`define SYS_CLK_NS      25
`define WRITE_TIME_NS   5000000
`define WRITE_CYCLES    (`WRITE_TIME_NS / `SYS_CLK_NS)
`define ADDR_BITS       13
`define ERASED_BYTE     8'hff
`define PROTECT_RESET   4'h0
`define PROTECT_SEL_BIT 7
`define PROTECT_LOCK    0
`define BIT_LAST        4'h7
`define BIT_ACK         4'h8
`endif

// ### eeprom_rd_pkg.sv
// types for the serial eeprom read and acknowledge-polling block
package eeprom_rd_pkg;
   typedef enum logic [5:0] {
      st_idle    = 6'b000001,
      st_select  = 6'b000010,
      st_addr_hi = 6'b000100,
      st_addr_lo = 6'b001000,
      st_wdata   = 6'b010000,
      st_rdata   = 6'b100000
   } link_state_type;

   typedef struct packed {
      logic        prot_sel;
      logic [15:0] addr;
      logic [7:0]  data;
   } wr_req_type;
endpackage

// ### bus_master_model.sv
// two-wire bus master model that drives the clock and pulls the data wire
`timescale 1ns/100ps
module bus_master_model (
   output logic      scl,       // serial clock to the device
   output logic      pull_low,  // high while this master pulls data low
   input  wire logic sda        // resolved data wire level
);
   initial begin
      scl      = 1'b1;
      pull_low = 1'b0;
   end
   // bare clocks, only around reset when no frame is open
   task automatic clocks(input int n);
      repeat (n) begin
         scl = 1'b0;
         #24 scl = 1'b1;
         #24;
      end
   endtask
   // start or repeated start: data falls while the clock is high
   task automatic start();
      scl = 1'b0;
      #12 pull_low = 1'b0;
      #12 scl = 1'b1;
      #12 pull_low = 1'b1;
      #12;
   endtask
   // stop: data rises while the clock is high
   task automatic stop();
      scl = 1'b0;
      #12 pull_low = 1'b1;
      #12 scl = 1'b1;
      #12 pull_low = 1'b0;
      #12;
   endtask
   // data only moves while the clock is low
   task automatic put_bit(input logic b);
      scl = 1'b0;
      #12 pull_low = ~b;
      #12 scl = 1'b1;
      #24;
   endtask
   // released line reads the pull-up unless the device drives it
   task automatic get_bit(output logic b);
      scl = 1'b0;
      #12 pull_low = 1'b0;
      #12 scl = 1'b1;
      #12 b = sda;
      #12;
   endtask
   // byte out msb first, acknowledge sampled in the 9th slot
   task automatic send(input logic [7:0] d, output logic ack);
      logic b;
      for (int i = 7; i >= 0; i--) put_bit(d[i]);
      get_bit(b);
      ack = ~b;
   endtask
   // byte in, then acknowledge or withhold it
   task automatic recv(input logic ack, output logic [7:0] d);
      for (int i = 7; i >= 0; i--) get_bit(d[i]);
      put_bit(~ack);
   endtask
endmodule

// ### serial_eeprom_read_and_poll_bench.sv
// self-checking bench for the serial eeprom read and polling block
`timescale 1ns/100ps
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin errors++; \
   $display("BAD t=%0t got %h expected %h", $time, got, exp); end end
module serial_eeprom_read_and_poll_bench;
   localparam logic [3:0] DEV_ID = 4'h5; // arbitrary value
   logic             sys_clk, reset_n, ack;
   wire logic        scl, pull_low, sda_out, sda_oe, write_busy;
   wire logic [3:0]  protect_bits;
   logic [2:0]       chip_enable;
   logic [3:0]       prot;
   logic [7:0]       d;
   logic [15:0]      a;
   logic [7:0]       mem [0:8191];
   int               errors, num_checks, seed, ctr, nack_cnt;
   wire logic        sda = ~(sda_oe | pull_low);

   eeprom_rd #(.WRITE_CYCLES(50), .DEV_TYPE(DEV_ID)) dut (.sys_clk(sys_clk), .reset_n(reset_n),
      .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .chip_enable(chip_enable),
      .write_busy(write_busy), .protect_bits(protect_bits));
   bus_master_model m (.scl(scl), .pull_low(pull_low), .sda(sda));

   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   task automatic end_of_test();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // expected read byte from the reference copy of array and protect bits
   function automatic logic [7:0] expect_byte(input logic is_prot, input int at);
      return is_prot ? {4'h0, prot} : mem[at];
   endfunction
   // poll with start plus write select; busy device must refuse
   task automatic poll();
      nack_cnt = 0;
      ack = 1'b0;
      while (!ack && nack_cnt < 40) begin
         m.start();
         m.send({DEV_ID, chip_enable, 1'b0}, ack);
         if (!ack) begin
            nack_cnt++;
            m.stop();
         end
      end
      if (!ack) begin
         errors++;
         $display("BAD t=%0t poll never acknowledged", $time);
         end_of_test();
      end
   endtask
   task automatic send_addr(input logic [15:0] x);
      m.send(x[15:8], ack);
      `CHK(ack, 1'b1)
      m.send(x[7:0], ack);
      `CHK(ack, 1'b1)
   endtask
   // byte write, then the next poll must see the busy period first
   task automatic wr(input logic [15:0] x, input logic [7:0] v);
      poll();
      send_addr(x);
      m.send(v, ack);
      `CHK(ack, 1'b1)
      m.stop();
      repeat (5) @(negedge sys_clk);
      `CHK(write_busy, 1'b1)
      poll();
      `CHK(nack_cnt > 0, 1'b1)
      `CHK(write_busy, 1'b0)
      m.stop();
      if (x[15]) begin
         if (!prot[0]) prot = v[3:0];
      end else begin
         mem[x[12:0]] = v;
         ctr = x[12:0];
      end
      $display("write at %h done", x);
   endtask
   // random read when cur is low, else current-address read
   task automatic rd(input logic [15:0] x, input int n, input logic cur);
      logic [7:0] exp;
      if (!cur) begin
         poll();
         send_addr(x);
         ctr = x[12:0];
      end
      m.start();
      m.send({DEV_ID, chip_enable, 1'b1}, ack);
      `CHK(ack, 1'b1)
      for (int i = 0; i < n; i++) begin
         m.recv(i < n - 1, d);
         exp = expect_byte(x[15], ctr);
         `CHK(d, exp)
         if (!x[15]) ctr = (ctr + 1) % 8192;
      end
      m.stop();
      `CHK(sda_oe, 1'b0)
      $display("read of %0d bytes done", n);
   endtask

   initial begin
      seed = 92471;
      reset_n = 1'b1;
      chip_enable = 3'h0;
      prot = 4'h0;
      ctr = 0;
      for (int i = 0; i < 8192; i++) mem[i] = 8'hff;
      // a real falling edge, so the asynchronously cleared flops see it
      #1 reset_n = 1'b0;
      #6;
      fork
         m.clocks(4);
         repeat (6) @(negedge sys_clk);
      join
      @(negedge sys_clk);
      chip_enable = 3'($random(seed));
      reset_n = 1'b1;
      m.clocks(3);
      `CHK(protect_bits, 4'h0)
      rd(16'h0, 3, 1'b1);
      repeat (4) begin
         a = 16'($random(seed)) & 16'h1fff;
         wr(a, 8'($random(seed)));
         rd(a, 1 + $unsigned($random(seed)) % 3, 1'b0);
      end
      rd(16'h0, 2, 1'b1);
      // top address then zero, so the stream must wrap
      wr(16'h1fff, 8'($random(seed)));
      wr(16'h0000, 8'($random(seed)));
      rd(16'h1fff, 3, 1'b0);
      // wrong type or chip enable gets no acknowledge
      for (int k = 0; k < 2; k++) begin
         m.start();
         m.send(k ? {DEV_ID, ~chip_enable, 1'b1} : {~DEV_ID, chip_enable, 1'b1}, ack);
         `CHK(ack, 1'b0)
         m.stop();
      end
      wr(16'h8000 | 16'($random(seed)), {4'($random(seed)), 4'b1110});
      `CHK(protect_bits, 4'b1110)
      rd(16'h8123, 3, 1'b0);
      rd(16'h0100, 2, 1'b0);
      wr(16'hffff, 8'h0f);
      wr(16'hc000, 8'h00);
      `CHK(protect_bits, 4'hf)
      rd(16'h8000, 2, 1'b0);
      `CHK(sda_out, 1'b0)
      end_of_test();
   end
   initial begin
      #1500000;
      errors++;
      $display("BAD t=%0t run did not finish", $time);
      end_of_test();
   end
endmodule
